// file: rtl/ssq_sequencer.sv
`include "ssq_defs.svh"
// Function
// - Buffer read-only, filled while module on
// - Buffer writes store thresholds while off
// - Buffer: 26 words, even, one per channel
// - Scan bit one includes, zero skips channel
// - Start by software, free-run, or hardware
// - Single, alternate two, or bitmap scan
// - 12-bit result, signed/unsigned, left/right
// - 10 or 12-bit resolution, 12 at reset
// - Auto store, FIFO or channel-indexed buffer
// - FIFO splits into two equal halves
// - Threshold compare, store or discard, flag
// - Flag on count, half ready, or hit
// - Flag restarts scan and, unless split, write pointer
// - Sleep interval wake, wake only on hit
// - Charge unit on only when requested
// - One hit flag per channel 0 to 15
// - Channel select picks inputs and negative
// - Sample held fixed during conversion
// - Conversion twelve periods, sample programmable
// - Trigger 0111 with auto runs continuously
// - 0001 pin edge, 0010 event trigger
module ssq_sequencer
  import ssq_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        pin_trig_i,
  input  wire logic        event_trig_i,
  input  wire logic        sleep_i,
  input  wire logic        conv_done_i,
  input  wire logic [11:0] conv_data_i,
  output logic             sample_o,
  output logic             conv_start_o,
  output logic      [4:0]  mux_pos_o,
  output logic      [2:0]  mux_neg_o,
  output logic             res12_o,
  output logic             charge_time_measurement_unit_on_o,
  output logic             flag_o,
  output logic             wake_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [7:0]  c1l_ff, c1h_ff, c2_ff, c3_ff, thc_ff, chsl_ff, chsh_ff;
  logic [15:0] scan_ff, charge_time_measurement_unit_ff, hit_ff;
  logic [15:0] buf_mem [`SSQ_BUF_WORDS];
  ssq_state_t  st_ff, nxt_st;
  logic [4:0]  tcnt_ff, cur_ch_ff, wp_ff, nxt_ch;
  logic [3:0]  scan_pos_ff, cnt_ff;
  logic [9:0]  wk_cnt_ff;
  logic        alt_ff, done_ff, half_ff, flag_ff, wake_ff, charge_time_measurement_unit_on_ff;
  logic        sample_ff, conv_start_ff, res12_ff;
  logic        pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic [11:0] res_ff;
  logic [7:0]  rdata_ff, rd_mux;
  ssq_result_t q_ff [2];
  logic        q_wp_ff, q_rp_ff;
  logic [1:0]  q_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions
  // Result formatting for resolution, sign and justification
  function automatic logic [15:0] fmt(input logic [11:0] d, input logic r12,
                                      input logic sgn, input logic lft);
    logic [15:0] w;
    w = r12 ? {4'h0, d} : {6'h00, d[11:2]};
    if (sgn && r12) w = {{4{~d[11]}}, ~d[11], d[10:0]};
    if (sgn && !r12) w = {{6{~d[11]}}, ~d[11], d[10:2]};
    if (lft) w = r12 ? {w[11:0], 4'h0} : {w[9:0], 6'h00};
    return w;
  endfunction

  // Next enabled scan channel after position p, wrapping
  function automatic logic [3:0] scan_next(input logic [15:0] m, input logic [3:0] p);
    logic [3:0] n;
    logic [3:0] r;
    r = p;
    for (int i = 16; i >= 1; i--) begin
      n = p + 4'(i);
      if (m[n]) r = n;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  wire        mod_on   = c1h_ff[`SSQ_ON_BIT];
  wire        res12    = c1h_ff[`SSQ_RES12_BIT];
  ssq_trig_t  trig;
  assign      trig     = ssq_trig_t'(c1l_ff[`SSQ_TRIG_LSB +: 4]);
  wire        auto_smp = c1l_ff[`SSQ_AUTO_BIT];
  wire        samp_bit = c1l_ff[`SSQ_SAMP_BIT];
  ssq_seq_t   seq;
  assign      seq      = ssq_seq_t'(c2_ff[`SSQ_SEQ_LSB +: 2]);
  wire        idx_mode = c2_ff[`SSQ_IDX_BIT];
  wire        split    = c2_ff[`SSQ_SPLIT_BIT] && !idx_mode;
  wire [3:0]  icnt     = c2_ff[`SSQ_ICNT_LSB +: 4];
  wire [4:0]  sample_time_count     = c3_ff[4:0];
  wire        thr_idx  = thc_ff[`SSQ_THREN_BIT] && idx_mode;
  wire [1:0]  cmp_mode = thc_ff[`SSQ_CMP_LSB +: 2];

  // Register port decode
  wire [7:0]  buf_off  = reg_addr_i - `SSQ_BUF_OFS;
  wire        buf_sel  = reg_addr_i >= `SSQ_BUF_OFS && buf_off < `SSQ_BUF_BYTES;
  wire [4:0]  buf_idx  = buf_off[5:1];
  wire        sw_we    = reg_wr_i && buf_sel && !mod_on;
  wire        hit_clrl = reg_wr_i && reg_addr_i == `SSQ_HITL_OFS;
  wire        hit_clrh = reg_wr_i && reg_addr_i == `SSQ_HITH_OFS;
  wire        flag_clr = reg_wr_i && reg_addr_i == `SSQ_STAT_OFS
                         && !reg_wdata_i[0];

  // Trigger pin edge after two-stage synchroniser
  wire pin_edge = c1l_ff[`SSQ_EDGE_BIT] ? (pin_s2_ff && !pin_s3_ff)
                                        : (!pin_s2_ff && pin_s3_ff);
  wire wake_tick = sleep_i && wk_cnt_ff == `SSQ_WAKE_CYC - 10'd1;

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry result buffer between converter and result store
  wire         in_valid  = st_ff == ST_PUSH;
  wire         in_ready  = q_n_ff != 2'd2;
  wire         out_valid = q_n_ff != 2'd0;
  wire         out_ready = !(reg_rd_i && buf_sel);
  wire         q_push    = in_valid && in_ready;
  wire         q_pop     = out_valid && out_ready;
  ssq_result_t ent;
  assign       ent       = q_ff[q_rp_ff];

  ////////////////////////////////////////////////////////////////////////////
  // Start, sample end and conversion end conditions
  wire start_req = mod_on && (sleep_i ? wake_tick : (auto_smp || samp_bit));
  wire smp_end   = (sleep_i || trig == TRG_AUTO) ? tcnt_ff >= sample_time_count :
                   trig == TRG_PIN   ? pin_edge :
                   trig == TRG_EVENT ? event_trig_i : !samp_bit;
  wire conv_end  = tcnt_ff >= `SSQ_CONV_LAST && (done_ff || conv_done_i);

  // Channel for next conversion
  wire [3:0] scan_ch = scan_next(scan_ff, scan_pos_ff);
  always_comb begin
    case (seq)
      SEQ_ALT:  nxt_ch = alt_ff ? chsh_ff[4:0] : chsl_ff[4:0];
      SEQ_SCAN: nxt_ch = {1'b0, scan_ch};
      default:  nxt_ch = chsl_ff[4:0];
    endcase
  end

  // Sequencer next state
  always_comb begin
    case (st_ff)
      ST_IDLE:   nxt_st = start_req ? ST_SAMPLE : ST_IDLE;
      ST_SAMPLE: nxt_st = !mod_on ? ST_IDLE : smp_end ? ST_CONV : ST_SAMPLE;
      ST_CONV:   nxt_st = conv_end ? ST_PUSH : ST_CONV;
      ST_PUSH:   nxt_st = in_ready ? ST_IDLE : ST_PUSH;
      default:   nxt_st = ST_IDLE;
    endcase
  end
  wire smp_go  = st_ff == ST_IDLE && nxt_st == ST_SAMPLE;
  wire conv_go = st_ff == ST_SAMPLE && nxt_st == ST_CONV;

  ////////////////////////////////////////////////////////////////////////////
  // Result store: write address, compare, flag conditions
  wire [11:0] thr_val  = buf_mem[ent.ch][11:0];
  wire        match    = cmp_mode == 2'b00 ? ent.data < thr_val :
                         cmp_mode == 2'b01 ? ent.data >= thr_val :
                         cmp_mode == 2'b10 ? ent.data != thr_val : ent.data == thr_val;
  wire        ch_ok    = ent.ch <= `SSQ_BUF_LAST;
  wire [4:0]  hw_addr  = idx_mode ? ent.ch : wp_ff;
  wire        hw_we    = q_pop && mod_on && (!idx_mode || ch_ok)
                         && (!thr_idx || match);
  wire        hit_set  = q_pop && thr_idx && match && !ent.ch[4];
  wire [4:0]  nxt_wp   = wp_ff == `SSQ_BUF_LAST ? 5'd0 : wp_ff + 5'd1;
  wire        half_end = split && (nxt_wp == `SSQ_BUF_HALF || nxt_wp == 5'd0);
  wire        flag_set = q_pop && (thr_idx ? match :
                                   split ? half_end : cnt_ff == icnt);
  wire [15:0] hit_one  = 16'h0001 << ent.ch[3:0];

  // Result memory, hardware fill or software threshold write
  always_ff @(posedge clk_sys_i) begin
    if (hw_we) buf_mem[hw_addr] <= fmt(ent.data, res12, c1h_ff[`SSQ_SIGNED_BIT],
                                       c1h_ff[`SSQ_LEFT_BIT]);
    else if (sw_we && reg_addr_i[0]) buf_mem[buf_idx][15:8] <= reg_wdata_i;
    else if (sw_we) buf_mem[buf_idx][7:0] <= reg_wdata_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and configuration registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c1l_ff  <= `SSQ_ZERO_RST;
      c1h_ff  <= `SSQ_CTRL1H_RST;
      c2_ff   <= `SSQ_ZERO_RST;
      c3_ff   <= `SSQ_ZERO_RST;
      thc_ff  <= `SSQ_ZERO_RST;
      chsl_ff <= `SSQ_ZERO_RST;
      chsh_ff <= `SSQ_ZERO_RST;
      scan_ff <= {`SSQ_ZERO_RST, `SSQ_ZERO_RST};
      charge_time_measurement_unit_ff <= {`SSQ_ZERO_RST, `SSQ_ZERO_RST};
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `SSQ_CTRL1L_OFS: c1l_ff <= reg_wdata_i;
        `SSQ_CTRL1H_OFS: c1h_ff <= reg_wdata_i;
        `SSQ_CTRL2_OFS:  c2_ff <= reg_wdata_i;
        `SSQ_CTRL3_OFS:  c3_ff <= reg_wdata_i;
        `SSQ_THRC_OFS:   thc_ff <= reg_wdata_i;
        `SSQ_CHSL_OFS:   chsl_ff <= reg_wdata_i;
        `SSQ_CHSH_OFS:   chsh_ff <= reg_wdata_i;
        `SSQ_SCANL_OFS:  scan_ff[7:0] <= reg_wdata_i;
        `SSQ_SCANH_OFS:  scan_ff[15:8] <= reg_wdata_i;
        `SSQ_CTMUL_OFS:  charge_time_measurement_unit_ff[7:0] <= reg_wdata_i;
        `SSQ_CTMUH_OFS:  charge_time_measurement_unit_ff[15:8] <= reg_wdata_i;
        default:         c1l_ff <= c1l_ff;
      endcase
    end else if (conv_go && trig != TRG_SOFT && !auto_smp) begin
      c1l_ff[`SSQ_SAMP_BIT] <= 1'b0;
    end
  end

  // Sequencer state, counters and analog handshake outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff         <= ST_IDLE;
      tcnt_ff       <= 5'd0;
      done_ff       <= 1'b0;
      res_ff        <= 12'h000;
      cur_ch_ff     <= 5'd0;
      sample_ff     <= 1'b0;
      conv_start_ff <= 1'b0;
      charge_time_measurement_unit_on_ff    <= 1'b0;
      res12_ff      <= 1'b1;
    end else begin
      st_ff         <= nxt_st;
      tcnt_ff       <= (st_ff != nxt_st) ? 5'd0 : (&tcnt_ff) ? tcnt_ff : tcnt_ff + 5'd1;
      done_ff       <= st_ff == ST_CONV && !conv_end && (done_ff || conv_done_i);
      if (st_ff == ST_CONV && conv_done_i) res_ff <= conv_data_i;
      if (smp_go) cur_ch_ff <= nxt_ch;
      sample_ff     <= nxt_st == ST_SAMPLE;
      conv_start_ff <= conv_go;
      charge_time_measurement_unit_on_ff    <= (nxt_st == ST_SAMPLE || nxt_st == ST_CONV)
                       && charge_time_measurement_unit_ff[smp_go ? nxt_ch[3:0] : cur_ch_ff[3:0]]
                       && !(smp_go ? nxt_ch[4] : cur_ch_ff[4]);
      res12_ff      <= res12;
    end
  end

  // Scan position, alternation, write pointer and count; flag restarts all but a split write pointer
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scan_pos_ff <= 4'hf;
      alt_ff      <= 1'b0;
      wp_ff       <= 5'd0;
      cnt_ff      <= 4'h0;
      half_ff     <= 1'b0;
    end else if (flag_set || !mod_on) begin
      scan_pos_ff <= 4'hf;
      alt_ff      <= 1'b0;
      wp_ff       <= (split && mod_on) ? nxt_wp : 5'd0;
      cnt_ff      <= 4'h0;
      half_ff     <= mod_on && (half_end ^ half_ff);
    end else begin
      if (smp_go && seq == SEQ_SCAN) scan_pos_ff <= scan_ch;
      if (smp_go && seq == SEQ_ALT) alt_ff <= !alt_ff;
      if (q_pop && !idx_mode) wp_ff <= nxt_wp;
      if (q_pop) cnt_ff <= cnt_ff + 4'h1;
    end
  end

  // Two-entry buffer storage and pointers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_ff[0] <= '0;
      q_ff[1] <= '0;
      q_wp_ff <= 1'b0;
      q_rp_ff <= 1'b0;
      q_n_ff  <= 2'd0;
    end else begin
      if (q_push) q_ff[q_wp_ff] <= '{ch: cur_ch_ff, data: res_ff};
      if (q_push) q_wp_ff <= !q_wp_ff;
      if (q_pop) q_rp_ff <= !q_rp_ff;
      q_n_ff <= q_n_ff + {1'b0, q_push} - {1'b0, q_pop};
    end
  end

  // Hit flags, interrupt flag, sleep wake; hardware set wins over clear
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hit_ff    <= 16'h0000;
      flag_ff   <= 1'b0;
      wake_ff   <= 1'b0;
      wk_cnt_ff <= 10'd0;
    end else begin
      hit_ff[7:0]  <= (hit_ff[7:0] & ~({8{hit_clrl}} & reg_wdata_i)) | hit_one[7:0]
                      & {8{hit_set}};
      hit_ff[15:8] <= (hit_ff[15:8] & ~({8{hit_clrh}} & reg_wdata_i)) | hit_one[15:8]
                      & {8{hit_set}};
      flag_ff   <= flag_set || (flag_ff && !flag_clr);
      wake_ff   <= sleep_i && (wake_ff || hit_set);
      wk_cnt_ff <= (!sleep_i || wake_tick) ? 10'd0 : wk_cnt_ff + 10'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read path
  always_comb begin
    case (reg_addr_i)
      `SSQ_CTRL1L_OFS: rd_mux = c1l_ff;
      `SSQ_CTRL1H_OFS: rd_mux = c1h_ff;
      `SSQ_CTRL2_OFS:  rd_mux = c2_ff;
      `SSQ_CTRL3_OFS:  rd_mux = c3_ff;
      `SSQ_THRC_OFS:   rd_mux = thc_ff;
      `SSQ_CHSL_OFS:   rd_mux = chsl_ff;
      `SSQ_CHSH_OFS:   rd_mux = chsh_ff;
      `SSQ_SCANL_OFS:  rd_mux = scan_ff[7:0];
      `SSQ_SCANH_OFS:  rd_mux = scan_ff[15:8];
      `SSQ_CTMUL_OFS:  rd_mux = charge_time_measurement_unit_ff[7:0];
      `SSQ_CTMUH_OFS:  rd_mux = charge_time_measurement_unit_ff[15:8];
      `SSQ_HITL_OFS:   rd_mux = hit_ff[7:0];
      `SSQ_HITH_OFS:   rd_mux = hit_ff[15:8];
      `SSQ_STAT_OFS:   rd_mux = {4'h0, wake_ff, half_ff, st_ff != ST_IDLE, flag_ff};
      default:         rd_mux = !buf_sel ? 8'h00 : reg_addr_i[0] ? buf_mem[buf_idx][15:8]
                                                                 : buf_mem[buf_idx][7:0];
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) rdata_ff <= 8'h00;
    else rdata_ff <= rd_mux;
  end

  // Pin synchroniser
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) {pin_s1_ff, pin_s2_ff, pin_s3_ff} <= 3'b000;
    else {pin_s1_ff, pin_s2_ff, pin_s3_ff} <= {pin_trig_i, pin_s1_ff, pin_s2_ff};
  end

  // Outputs
  assign reg_rdata_o  = rdata_ff;
  assign sample_o     = sample_ff;
  assign conv_start_o = conv_start_ff;
  assign mux_pos_o    = cur_ch_ff;
  assign mux_neg_o    = chsh_ff[`SSQ_NEG_LSB +: 3];
  assign res12_o      = res12_ff;
  assign charge_time_measurement_unit_on_o    = charge_time_measurement_unit_on_ff;
  assign flag_o       = flag_ff;
  assign wake_o       = wake_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_buf_owner;
    (reg_wr_i && buf_sel && mod_on && !(hw_we && hw_addr == buf_idx))
      |=> buf_mem[$past(buf_idx)] == $past(buf_mem[buf_idx]);
  endproperty
  a_buf_owner: assert property (p_buf_owner) else $error("buffer write while on");

  property p_hold;
    conv_start_o |-> !sample_o [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("sample moved in conversion");

  property p_conv_len;
    conv_start_o |-> ##11 (st_ff == ST_CONV);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion too short");

  property p_restart;
    flag_set |=> scan_pos_ff == 4'hf && !alt_ff && cnt_ff == 4'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart on flag");

  property p_flag;
    flag_set |=> flag_o;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not raised");

  property p_scan;
    $rose(sample_o) && seq == SEQ_SCAN && scan_ff != 16'h0000 |-> scan_ff[mux_pos_o[3:0]];
  endproperty
  a_scan: assert property (p_scan) else $error("skipped channel sampled");

  property p_discard;
    q_pop && thr_idx && !match |-> !hw_we;
  endproperty
  a_discard: assert property (p_discard) else $error("miss stored");

  property p_pin;
    st_ff == ST_SAMPLE && mod_on && !sleep_i && trig == TRG_PIN && pin_edge |=> conv_start_o;
  endproperty
  a_pin: assert property (p_pin) else $error("pin trigger missed");

  property p_wake;
    !sleep_i |=> !wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake outside sleep");

  c_flag:  cover property (flag_set);
  c_hit:   cover property (hit_set);
  c_stall: cover property (in_valid && !in_ready);
  c_half:  cover property (half_end && q_pop);
endmodule

// file: rtl/ssq_defs.svh
`ifndef SSQ_DEFS_SVH
`define SSQ_DEFS_SVH
// Register offsets on the byte-wide register port
`define SSQ_CTRL1L_OFS 8'h00
`define SSQ_CTRL1H_OFS 8'h01
`define SSQ_CTRL2_OFS  8'h02
`define SSQ_CTRL3_OFS  8'h03
`define SSQ_THRC_OFS   8'h04
`define SSQ_CHSL_OFS   8'h05
`define SSQ_CHSH_OFS   8'h06
`define SSQ_SCANL_OFS  8'h07
`define SSQ_SCANH_OFS  8'h08
`define SSQ_CTMUL_OFS  8'h09
`define SSQ_CTMUH_OFS  8'h0a
`define SSQ_HITL_OFS   8'h0b
`define SSQ_HITH_OFS   8'h0c
`define SSQ_STAT_OFS   8'h0d
`define SSQ_BUF_OFS    8'h20
`define SSQ_BUF_BYTES  8'd52
// Reset values
`define SSQ_CTRL1H_RST 8'h40
`define SSQ_ZERO_RST   8'h00
// Field positions
`define SSQ_ON_BIT     7
`define SSQ_RES12_BIT  6
`define SSQ_SIGNED_BIT 5
`define SSQ_LEFT_BIT   4
`define SSQ_TRIG_LSB   4
`define SSQ_AUTO_BIT   2
`define SSQ_SAMP_BIT   1
`define SSQ_EDGE_BIT   0
`define SSQ_SEQ_LSB    0
`define SSQ_IDX_BIT    2
`define SSQ_SPLIT_BIT  3
`define SSQ_ICNT_LSB   4
`define SSQ_THREN_BIT  0
`define SSQ_CMP_LSB    1
`define SSQ_NEG_LSB    5
// Buffer geometry
`define SSQ_BUF_WORDS  26
`define SSQ_BUF_HALF   5'd13
`define SSQ_BUF_LAST   5'd25
// Timing: converter clock period, fixed conversion length, wake interval
`define SSQ_CLK_NS     4
`define SSQ_TAD_NS     4
`define SSQ_TCONV_TAD  12
`define SSQ_TAD_CYC    ((`SSQ_TAD_NS + `SSQ_CLK_NS - 1) / `SSQ_CLK_NS)
`define SSQ_CONV_LAST  5'((`SSQ_TCONV_TAD * `SSQ_TAD_CYC) - 1)
`define SSQ_WAKE_CYC   10'd1000
`endif

// file: rtl/ssq_pkg.sv
package ssq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b10,
    ST_PUSH   = 2'b11
  } ssq_state_t;
  typedef enum logic [3:0] {
    TRG_SOFT  = 4'h0,
    TRG_PIN   = 4'h1,
    TRG_EVENT = 4'h2,
    TRG_AUTO  = 4'h7
  } ssq_trig_t;
  typedef enum logic [1:0] {
    SEQ_SINGLE = 2'b00,
    SEQ_ALT    = 2'b01,
    SEQ_SCAN   = 2'b10
  } ssq_seq_t;
  typedef struct packed {
    logic [4:0]  ch;
    logic [11:0] data;
  } ssq_result_t;
endpackage

// file: tb/ssq_core_model.sv
// Behavioural converter core: one result per conversion start
module ssq_core_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        conv_start_i,
  input  wire logic        slow_i,
  input  wire logic [4:0]  mux_pos_i,
  output logic             conv_done_o,
  output logic      [11:0] conv_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       [4:0] held_ff;
  logic       [5:0] cnt_ff;
  logic             busy_ff;
  logic       [5:0] dly;
  // Prompt answer inside the conversion window, slow answer well after it
  assign dly = slow_i ? 6'd30 : 6'd4;
  ////////////////////////////////////////////////////////////////////////////////
  // Channel captured at start and held for the whole conversion
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held_ff     <= 5'h00;
      cnt_ff      <= 6'h00;
      busy_ff     <= 1'b0;
      conv_done_o <= 1'b0;
      conv_data_o <= 12'h000;
    end else begin
      conv_done_o <= 1'b0;
      conv_data_o <= conv_data_o + 12'h5a3; // Junk between results
      if (conv_start_i) begin
        held_ff <= mux_pos_i;
        busy_ff <= 1'b1;
        cnt_ff  <= 6'h00;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff + 6'h01;
        if (cnt_ff == dly) begin
          busy_ff     <= 1'b0;
          conv_done_o <= 1'b1;
          conv_data_o <= {held_ff, 7'h2a};
        end
      end
    end
  end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the scan sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i;
  logic        rst_n_i;
  logic [7:0]  reg_addr_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_wdata_i;
  logic [7:0]  reg_rdata_o;
  logic        pin_trig_i;
  logic        event_trig_i;
  logic        sleep_i;
  logic        conv_done_i;
  logic [11:0] conv_data_i;
  logic        sample_o;
  logic        conv_start_o;
  logic [4:0]  mux_pos_o;
  logic [2:0]  mux_neg_o;
  logic        res12_o;
  logic        charge_time_measurement_unit_on_o;
  logic        flag_o;
  logic        wake_o;
  logic        slow;
  logic [7:0]  tick;
  logic        smp_prev;
  logic        charge_time_measurement_unit_exp;
  int          n_errors;
  int          checked;
  int          cycles;
  logic [7:0]  trig_codes [3];
  logic [15:0] w;

  ssq_sequencer ssq_sequencer_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .pin_trig_i(pin_trig_i),
    .event_trig_i(event_trig_i), .sleep_i(sleep_i), .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i), .sample_o(sample_o), .conv_start_o(conv_start_o),
    .mux_pos_o(mux_pos_o), .mux_neg_o(mux_neg_o), .res12_o(res12_o),
    .charge_time_measurement_unit_on_o(charge_time_measurement_unit_on_o), .flag_o(flag_o), .wake_o(wake_o));
  ssq_core_model ssq_core_model_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .conv_start_i(conv_start_o), .slow_i(slow), .mux_pos_i(mux_pos_o),
    .conv_done_o(conv_done_i), .conv_data_o(conv_data_i));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, hardware triggers and hang limit
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    tick         <= tick + 8'h01;
    event_trig_i <= (tick[5:0] == 6'h00);
    pin_trig_i   <= tick[5];
    smp_prev     <= sample_o;
    // Sample ends as the conversion starts; charge unit follows its enable
    if (conv_start_o === 1'b1) begin
      check("sample_o before start", 16'h0001, {15'h0000, smp_prev});
      check("sample_o at start", 16'h0000, {15'h0000, sample_o});
      check("charge_time_measurement_unit_on_o", {15'h0000, charge_time_measurement_unit_exp}, {15'h0000, charge_time_measurement_unit_on_o});
    end
    cycles       = cycles + 1;
    if (cycles == 30000) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register port access and comparison
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(name, {8'h00, exp}, {8'h00, d});
  endtask
  task automatic rd_word(input int i, output logic [15:0] v);
    rd(8'h20 + 8'(2 * i), v[7:0]);
    rd(8'h21 + 8'(2 * i), v[15:8]);
  endtask
  task automatic wait_flag();
    int n;
    n = 0;
    while (flag_o !== 1'b1 && n < 2000) begin
      @(posedge clk_sys_i);
      n = n + 1;
    end
    check("flag_o", 16'h0001, {15'h0000, flag_o});
  endtask
  // Disable, let a running conversion drain, then clear the flag
  task automatic stop_conv();
    wr(8'h01, 8'h40);
    repeat (64) @(posedge clk_sys_i);
    wr(8'h0d, 8'h00);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_errors = 0;
    checked = 0;
    cycles = 0;
    tick = 8'h00;
    rst_n_i = 1'b0;
    {reg_wr_i, reg_rd_i, pin_trig_i, event_trig_i, sleep_i, slow, charge_time_measurement_unit_exp} = 7'h00;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    trig_codes = '{8'h74, 8'h24, 8'h15};
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd_chk("ctrl1h reset", 8'h01, 8'h40);
    rd_chk("scan_select_high reset", 8'h08, 8'h00);
    check("res12_o", 16'h0001, {15'h0000, res12_o});
    rd_chk("unmapped", 8'h1f, 8'h00);
    wr(8'h08, 8'ha5);
    rd_chk("scan_select_high rw", 8'h08, 8'ha5);
    wr(8'h08, 8'h00);
    // Buffer writable while off
    wr(8'h22, 8'h3c);
    wr(8'h23, 8'h0b);
    rd_word(1, w);
    check("threshold word", 16'h0b3c, w);
    wr(8'h06, 8'ha0);
    wr(8'h01, 8'h00);
    repeat (2) @(posedge clk_sys_i);
    check("mux_neg_o", 16'h0005, {13'h0000, mux_neg_o});
    check("res12_o low", 16'h0000, {15'h0000, res12_o});
    // Single channel under free-run, event and pin triggers
    wr(8'h05, 8'h03);
    wr(8'h02, 8'h00);
    for (int i = 0; i < 3; i++) begin
      slow <= i[0];
      stop_conv();
      wr(8'h20, 8'h00);
      wr(8'h21, 8'h00);
      wr(8'h00, trig_codes[i]);
      wr(8'h01, 8'hc0);
      wait_flag();
      rd_word(0, w);
      check("single word0", 16'h01aa, w);
    end
    // Buffer read-only while on
    wr(8'h22, 8'h55);
    rd_chk("buffer locked", 8'h22, 8'h3c);
    // Bitmap scan of channels 0 and 2, left justified, flag per two
    stop_conv();
    wr(8'h07, 8'h05);
    wr(8'h02, 8'h12);
    wr(8'h00, 8'h74);
    wr(8'h01, 8'hd0);
    wait_flag();
    stop_conv();
    rd_word(0, w);
    check("scan word0", 16'h02a0, w);
    rd_word(1, w);
    check("scan word1", 16'h12a0, w);
    // Indexed threshold compare in sleep, charge unit on channel 3
    wr(8'h26, 8'h00);
    wr(8'h27, 8'h01);
    wr(8'h02, 8'h04);
    wr(8'h04, 8'h03);
    wr(8'h09, 8'h08);
    charge_time_measurement_unit_exp <= 1'b1;
    sleep_i  <= 1'b1;
    wr(8'h01, 8'hc0);
    wait_flag();
    check("wake_o", 16'h0001, {15'h0000, wake_o});
    rd_chk("hit low", 8'h0b, 8'h08);
    stop_conv();
    sleep_i <= 1'b0;
    rd_word(3, w);
    check("threshold word3", 16'h01aa, w);
    check("wake_o cleared", 16'h0000, {15'h0000, wake_o});
    wr(8'h0b, 8'h08);
    rd_chk("hit cleared", 8'h0b, 8'h00);
    complete_run();
  end
endmodule
